// ### shared/uoef_pkg.sv
// Package with register map, field positions and timing constants for the USB event block
package uoef_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] OFS_CFG2 = 4'h0;
    localparam logic [3:0] OFS_OTG_STAT = 4'h1;
    localparam logic [3:0] OFS_OTG_EN = 4'h2;
    localparam logic [3:0] OFS_DEV_STAT = 4'h3;
    localparam logic [3:0] OFS_DEV_EN = 4'h4;
    localparam logic [3:0] OFS_ERR_EN = 4'h5;
    localparam logic [3:0] OFS_PWR = 4'h6;
    localparam logic [15:0] CFG2_MASK = 16'h001f;
    localparam logic [15:0] OTG_MASK = 16'h00fd;
    localparam logic [15:0] DEV_MASK = 16'h00bf;
    localparam logic [15:0] DEV_W1C_MASK = 16'h00bd;
    localparam logic [15:0] ERR_MASK = 16'h00bf;
    localparam logic [15:0] PWR_MASK = 16'h0001;
    localparam logic [15:0] PHY_LOCK_MASK = 16'h0007;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam int unsigned B_PULLUP = 4;
    localparam int unsigned B_SERIAL = 3;
    localparam int unsigned B_BOOST = 2;
    localparam int unsigned B_VCMP = 1;
    localparam int unsigned B_XCVR = 0;
    localparam int unsigned B_ID = 7;
    localparam int unsigned B_MS = 6;
    localparam int unsigned B_LSTATE = 5;
    localparam int unsigned B_ACTV = 4;
    localparam int unsigned B_SESVD = 3;
    localparam int unsigned B_SESEND = 2;
    localparam int unsigned B_VBUSVD = 0;
    localparam int unsigned B_STALL = 7;
    localparam int unsigned B_RESUME = 5;
    localparam int unsigned B_IDLE = 4;
    localparam int unsigned B_TRN = 3;
    localparam int unsigned B_SOF = 2;
    localparam int unsigned B_ERR = 1;
    localparam int unsigned B_URST = 0;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MS_US = 1000;
    localparam int unsigned IDLE_US = 3000;
    localparam int unsigned K_NS = 2500;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned MS_CYC = MS_US * CLK_MHZ;
    localparam int unsigned IDLE_CYC = IDLE_US * CLK_MHZ;
    localparam int unsigned K_CYC = (K_NS + CLK_NS - 1) / CLK_NS;
endpackage : uoef_pkg

// ### src/uoef_top.sv
// USB OTG event flags, enables and transceiver selection logic
// Function
// - pull-up bit drives VBUS pull-up enable
// - serial bit selects I2C external control
// - boost disable bit selects digital output
// - comparator disable selects digital status input
// - transceiver disable selects external transceiver
// - ID pin change sets flag
// - one millisecond timer sets flag
// - new stable line state sets flag
// - line or VBUS activity sets flag
// - session-end A crossing sets flag, both edges
// - B session-end crossing sets flag
// - VBUS valid crossing sets flag
// - writing one clears flag only; error summary bit is not cleared, it follows enabled errors
// - per-flag enable bits, reset disabled
// - sent stall sets flag; bit6 zero
// - K-state for 2.5 us sets resume
// - idle 3 ms sets idle flag
// - token done flag; clear pops FIFO
// - start-of-frame sets frame flag
// - error summary only from enabled errors
// - bus reset 2.5 us, once per reset
`timescale 1ns/1ps
module uoef_top
    import uoef_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC,
    parameter int unsigned IDLE_CYCLES = IDLE_CYC,
    parameter int unsigned K_CYCLES = K_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic id_pin_i,
    input wire logic single_ended_zero_state_i,
    input wire logic j_state_indication_i,
    input wire logic k_state_i,
    input wire logic bus_idle_i,
    input wire logic vbus_activity_i,
    input wire logic a_sess_end_i,
    input wire logic b_sess_end_i,
    input wire logic a_vbus_valid_i,
    input wire logic stall_sent_i,
    input wire logic token_done_i,
    input wire logic frame_start_i,
    input wire logic [7:0] error_events_i,
    output logic vbus_pullup_en_o,
    output logic ext_module_serial_ctrl_en_o,
    output logic boost_builder_disable_o,
    output logic vbus_comparator_disable_o,
    output logic transceiver_disable_o,
    output logic module_power_on_o,
    output logic status_fifo_advance_o,
    output logic irq_o
);
    typedef logic [DATA_W-1:0] uoef_word_t;

    function automatic logic wr_hit(input logic we, input logic [ADDR_W-1:0] a,
                                    input logic [3:0] ofs);
        return we && (a == ofs);
    endfunction : wr_hit

    function automatic logic [31:0] cnt_step(input logic [31:0] c, input logic run,
                                             input logic [31:0] lim);
        if (!run) begin
            return 32'h0;
        end
        return (c >= lim) ? c : c + 32'h1;
    endfunction : cnt_step

    // Pin synchronisers: stage one is read only by stage two
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {stall_sent_i, token_done_i, frame_start_i, bus_idle_i, k_state_i,
                     vbus_activity_i, a_vbus_valid_i, b_sess_end_i, a_sess_end_i,
                     1'b0,
                     id_pin_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic [1:0] ln1_q, ln2_q;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ln1_q <= '0;
            ln2_q <= '0;
        end else begin
            ln1_q <= {single_ended_zero_state_i, j_state_indication_i};
            ln2_q <= ln1_q;
        end
    end
    logic [7:0] err1_q, err2_q;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            err1_q <= '0;
            err2_q <= '0;
        end else begin
            err1_q <= error_events_i;
            err2_q <= err1_q;
        end
    end

    wire logic id_s = s2_q[0];
    wire logic asess_s = s2_q[2];
    wire logic bsess_s = s2_q[3];
    wire logic avld_s = s2_q[4];
    wire logic actv_s = s2_q[5];
    wire logic k_s = s2_q[6];
    wire logic idle_s = s2_q[7];
    wire logic sof_e = s2_q[8] & ~s3_q[8];
    wire logic trn_e = s2_q[9] & ~s3_q[9];
    wire logic stall_e = s2_q[10] & ~s3_q[10];

    // Configuration registers
    uoef_word_t cfg_q, otg_en_q, dev_en_q, err_en_q, pwr_q;
    wire logic phy_locked = pwr_q[0];
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cfg_q <= RST_ZERO;
        end else if (wr_hit(wr_i, addr_i, OFS_CFG2)) begin
            // Phy selection bits are held while powered
            cfg_q <= phy_locked ? ((wdata_i & CFG2_MASK & ~PHY_LOCK_MASK)
                                   | (cfg_q & PHY_LOCK_MASK)) : (wdata_i & CFG2_MASK);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            otg_en_q <= RST_ZERO;
            dev_en_q <= RST_ZERO;
            err_en_q <= RST_ZERO;
            pwr_q <= RST_ZERO;
        end else begin
            if (wr_hit(wr_i, addr_i, OFS_OTG_EN)) otg_en_q <= wdata_i & OTG_MASK;
            if (wr_hit(wr_i, addr_i, OFS_DEV_EN)) dev_en_q <= wdata_i & DEV_MASK;
            if (wr_hit(wr_i, addr_i, OFS_ERR_EN)) err_en_q <= wdata_i & ERR_MASK;
            if (wr_hit(wr_i, addr_i, OFS_PWR)) pwr_q <= wdata_i & PWR_MASK;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            vbus_pullup_en_o <= 1'b0;
            ext_module_serial_ctrl_en_o <= 1'b0;
            boost_builder_disable_o <= 1'b0;
            vbus_comparator_disable_o <= 1'b0;
            transceiver_disable_o <= 1'b0;
            module_power_on_o <= 1'b0;
        end else begin
            vbus_pullup_en_o <= cfg_q[B_PULLUP];
            ext_module_serial_ctrl_en_o <= cfg_q[B_SERIAL];
            boost_builder_disable_o <= cfg_q[B_BOOST];
            vbus_comparator_disable_o <= cfg_q[B_VCMP];
            transceiver_disable_o <= cfg_q[B_XCVR];
            module_power_on_o <= pwr_q[0];
        end
    end

    // Level history for change detection
    logic id_h_q, asess_h_q, bsess_h_q, avld_h_q, hist_ok_q;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            id_h_q <= 1'b0;
            asess_h_q <= 1'b0;
            bsess_h_q <= 1'b0;
            avld_h_q <= 1'b0;
            hist_ok_q <= 1'b0;
        end else begin
            id_h_q <= id_s;
            asess_h_q <= asess_s;
            bsess_h_q <= bsess_s;
            avld_h_q <= avld_s;
            hist_ok_q <= 1'b1;
        end
    end

    // Millisecond timer and line-state stability counter
    logic [31:0] ms_q, ls_q, k_q, idle_q;
    logic [1:0] ln_last_q, ln_stable_q;
    wire logic ms_tick = (ms_q == MS_CYCLES - 1);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ms_q <= 32'h0;
        end else begin
            ms_q <= ms_tick ? 32'h0 : ms_q + 32'h1;
        end
    end
    wire logic ln_same = (ln2_q == ln_last_q);
    wire logic ls_fire = ln_same && (ls_q == MS_CYCLES - 1) && (ln2_q != ln_stable_q);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ls_q <= 32'h0;
            ln_last_q <= 2'h0;
            ln_stable_q <= 2'h0;
        end else begin
            ln_last_q <= ln2_q;
            ls_q <= cnt_step(ls_q, ln_same, MS_CYCLES);
            if (ls_fire) ln_stable_q <= ln2_q;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            k_q <= 32'h0;
            idle_q <= 32'h0;
        end else begin
            k_q <= cnt_step(k_q, k_s, K_CYCLES);
            idle_q <= cnt_step(idle_q, idle_s, IDLE_CYCLES);
        end
    end
    // The level must still stand in the last counted cycle, so a full period is seen
    wire logic k_fire = k_s && (k_q == K_CYCLES - 1);
    wire logic idle_fire = idle_s && (idle_q == IDLE_CYCLES - 1);

    // Bus reset: single-ended zero held long enough, once per reset
    logic [31:0] rst_q;
    wire logic se0_s = ln2_q[1];
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_q <= 32'h0;
        end else begin
            rst_q <= cnt_step(rst_q, se0_s, K_CYCLES);
        end
    end
    wire logic rst_fire = se0_s && (rst_q == K_CYCLES - 1);

    // Status flag registers: set beats a same-cycle clear
    uoef_word_t otg_set, dev_set, otg_q, dev_q;
    always_comb begin
        otg_set = RST_ZERO;
        otg_set[B_ID] = hist_ok_q && (id_s != id_h_q);
        otg_set[B_MS] = ms_tick;
        otg_set[B_LSTATE] = ls_fire;
        otg_set[B_ACTV] = actv_s || (ln2_q != ln_last_q);
        otg_set[B_SESVD] = hist_ok_q && (asess_s != asess_h_q);
        otg_set[B_SESEND] = hist_ok_q && (bsess_s != bsess_h_q);
        otg_set[B_VBUSVD] = hist_ok_q && (avld_s != avld_h_q);
    end
    always_comb begin
        dev_set = RST_ZERO;
        dev_set[B_STALL] = stall_e;
        dev_set[B_RESUME] = k_fire;
        dev_set[B_IDLE] = idle_fire;
        dev_set[B_TRN] = trn_e;
        dev_set[B_SOF] = sof_e;
        dev_set[B_URST] = rst_fire;
    end
    wire uoef_word_t otg_clr = wr_hit(wr_i, addr_i, OFS_OTG_STAT) ? wdata_i : RST_ZERO;
    wire uoef_word_t dev_clr = wr_hit(wr_i, addr_i, OFS_DEV_STAT) ? wdata_i : RST_ZERO;
    wire logic err_any = |(err2_q & err_en_q[7:0]);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            otg_q <= RST_ZERO;
        end else begin
            otg_q <= ((otg_q & ~otg_clr) | otg_set) & OTG_MASK;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dev_q <= RST_ZERO;
        end else begin
            dev_q <= (((dev_q & ~(dev_clr & DEV_W1C_MASK)) | dev_set) & DEV_W1C_MASK)
                     | (err_any ? (16'h1 << B_ERR) : RST_ZERO);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            status_fifo_advance_o <= 1'b0;
        end else begin
            status_fifo_advance_o <= dev_clr[B_TRN] && dev_q[B_TRN];
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(otg_q & otg_en_q) || |(dev_q & dev_en_q);
        end
    end

    // Read port: data in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= RST_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                OFS_CFG2: rdata_o <= cfg_q;
                OFS_OTG_STAT: rdata_o <= otg_q;
                OFS_OTG_EN: rdata_o <= otg_en_q;
                OFS_DEV_STAT: rdata_o <= dev_q;
                OFS_DEV_EN: rdata_o <= dev_en_q;
                OFS_ERR_EN: rdata_o <= err_en_q;
                OFS_PWR: rdata_o <= pwr_q;
                default: rdata_o <= RST_ZERO;
            endcase
        end else begin
            rdata_o <= RST_ZERO;
        end
    end

    a_otg_clear_one: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (otg_q[B_ID] && !otg_set[B_ID] && !otg_clr[B_ID]) |=> otg_q[B_ID])
        else $error("otg flag lost without clear");
    a_otg_clear_hit: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (otg_clr[B_MS] && !ms_tick) |=> !otg_q[B_MS])
        else $error("otg flag not cleared");
    a_otg_gaps_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        otg_q[1] == 1'b0 && otg_en_q[1] == 1'b0) else $error("unused bit set");
    a_dev_bit6_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dev_q[6] == 1'b0) else $error("device bit6 set");
    a_ms_tick_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ms_tick |=> otg_q[B_MS]) else $error("ms flag missing");
    a_id_change_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (hist_ok_q && id_s != id_h_q) |=> otg_q[B_ID]) else $error("id flag missing");
    a_err_summary: assert property (@(posedge clk_i) disable iff (!resetn_i)
        dev_q[B_ERR] == $past(err_any)) else $error("error summary wrong");
    a_irq_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 irq_o == $past(|(otg_q & otg_en_q) || |(dev_q & dev_en_q)))
        else $error("irq mismatch");
    a_pullup_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 vbus_pullup_en_o == $past(cfg_q[B_PULLUP])) else $error("pullup mismatch");
    a_phy_lock_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        phy_locked |=> cfg_q[2:0] == $past(cfg_q[2:0])) else $error("phy bits changed");
    a_reset_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rst_fire |=> !rst_fire) else $error("bus reset fired twice");
    a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (otg_set[B_MS] && otg_clr[B_MS]) |=> otg_q[B_MS])
        else $error("flag set lost to clear");
    a_dev_clear_hit: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (dev_clr[B_STALL] && !stall_e) |=> !dev_q[B_STALL])
        else $error("device flag not cleared");
    a_resume_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        k_fire |=> dev_q[B_RESUME])
        else $error("resume flag missing");
    a_idle_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        idle_fire |=> dev_q[B_IDLE])
        else $error("idle flag missing");
    a_bus_reset_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rst_fire |=> dev_q[B_URST])
        else $error("bus reset flag missing");
    a_line_stable_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ls_fire |=> otg_q[B_LSTATE])
        else $error("line stable flag missing");
    a_fifo_advance: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (dev_clr[B_TRN] && dev_q[B_TRN]) |=> status_fifo_advance_o)
        else $error("status fifo not advanced");
    a_otg_read_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == OFS_OTG_STAT) |=> rdata_o[1] == 1'b0)
        else $error("otg bit1 read as one");
    a_serial_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 ext_module_serial_ctrl_en_o == $past(cfg_q[B_SERIAL]))
        else $error("serial select mismatch");
    a_boost_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 boost_builder_disable_o == $past(cfg_q[B_BOOST]))
        else $error("boost disable mismatch");
    a_vcmp_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 vbus_comparator_disable_o == $past(cfg_q[B_VCMP]))
        else $error("comparator disable mismatch");
    a_xcvr_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 transceiver_disable_o == $past(cfg_q[B_XCVR]))
        else $error("transceiver disable mismatch");
    // Main scenarios that the bench is meant to reach
    c_id_flag: cover property (@(posedge clk_i) disable iff (!resetn_i) otg_set[B_ID]);
    c_trn_pop: cover property (@(posedge clk_i) disable iff (!resetn_i) status_fifo_advance_o);
    c_irq_up: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(irq_o));
    c_set_clear: cover property (@(posedge clk_i) disable iff (!resetn_i)
        (otg_set[B_MS] && otg_clr[B_MS]));
    c_resume_fire: cover property (@(posedge clk_i) disable iff (!resetn_i) k_fire);
endmodule : uoef_top

// ### sim/uoef_far_model.sv
// Cable-side partner model driving line states, VBUS levels and transaction events
`timescale 1ns/1ps
module uoef_far_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [8:0] lvl_i,
    input wire logic [2:0] evt_i,
    output logic [8:0] lvl_o,
    output logic [2:0] evt_o
);
    logic [8:0] lvl_p_q [3];
    logic [2:0] evt_sh_q [3];
    // Slow mode lags line changes by three cycles, like a long cable
    always_ff @(posedge clk_i) begin
        lvl_p_q[0] <= lvl_i;
        lvl_p_q[1] <= lvl_p_q[0];
        lvl_p_q[2] <= lvl_p_q[1];
    end
    assign lvl_o = slow_i ? lvl_p_q[2] : lvl_p_q[0];
    // Each event request becomes a three-cycle pulse so the synchroniser sees it
    always_ff @(posedge clk_i) begin
        evt_sh_q[0] <= evt_i;
        evt_sh_q[1] <= evt_sh_q[0];
        evt_sh_q[2] <= evt_sh_q[1];
    end
    assign evt_o = evt_sh_q[0] | evt_sh_q[1] | evt_sh_q[2];
endmodule : uoef_far_model

// ### sim/testbench.sv
// Self-checking bench for the USB event flag and PHY select block
`timescale 1ns/1ps
module testbench;
    import uoef_pkg::*;
    localparam int MSC = 20;
    localparam int IDC = 40;
    localparam int KC = 5;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic slow = 1'b0;
    logic [8:0] lvl = 9'h000;
    logic [2:0] evt = 3'h0;
    logic [7:0] err = 8'h00;
    logic [8:0] lv;
    logic [2:0] ev;
    logic [15:0] rdata_o;
    logic [5:0] cfg;
    logic fifo_adv;
    logic irq;
    logic rd_pend = 1'b0;
    logic [31:0] seed = 32'hd643;
    logic [31:0] note;
    logic [31:0] exp_q [$];
    int otg_lv [5] = '{8, 2, 1, 0, 3};
    int otg_fl [5] = '{7, 3, 2, 0, 4};
    int dev_fl [3] = '{2, 3, 7};
    int adv_cnt = 0;
    int adv_base = 0;
    int fail_count = 0;
    int num_checks = 0;

    uoef_far_model far (.clk_i(clk_i), .slow_i(slow), .lvl_i(lvl), .evt_i(evt), .lvl_o(lv),
        .evt_o(ev));
    uoef_top #(.MS_CYCLES(MSC), .IDLE_CYCLES(IDC), .K_CYCLES(KC)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .id_pin_i(lv[8]), .single_ended_zero_state_i(lv[7]),
        .j_state_indication_i(lv[6]), .k_state_i(lv[5]), .bus_idle_i(lv[4]),
        .vbus_activity_i(lv[3]), .a_sess_end_i(lv[2]), .b_sess_end_i(lv[1]),
        .a_vbus_valid_i(lv[0]), .stall_sent_i(ev[2]), .token_done_i(ev[1]),
        .frame_start_i(ev[0]), .error_events_i(err), .vbus_pullup_en_o(cfg[4]),
        .ext_module_serial_ctrl_en_o(cfg[3]), .boost_builder_disable_o(cfg[2]),
        .vbus_comparator_disable_o(cfg[1]), .transceiver_disable_o(cfg[0]),
        .module_power_on_o(cfg[5]), .status_fifo_advance_o(fifo_adv), .irq_o(irq));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Expected word and mask are queued; the monitor compares when data stands
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back({m | 16'hff00, e});
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_i) rd_pend <= rd_i;
    always @(negedge clk_i) begin
        if (fifo_adv === 1'b1) adv_cnt++;
        if (rd_pend) begin
            note = exp_q.pop_front();
            cmp(rdata_o & note[31:16], note[15:0] & note[31:16]);
        end
    end
    initial forever #5 clk_i = ~clk_i;
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end
    initial begin
        cyc(12);
        resetn_i <= 1'b1;
        for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000, (a == 1) ? 16'hffbf : 16'hffff);
        cmp({10'h000, cfg}, 16'h0000);
        $display("reset values done");
        for (int b = 0; b < 5; b++) begin
            wr(OFS_CFG2, 16'hffe0 | (16'h1 << b));
            cyc(2);
            #1 cmp({10'h000, cfg}, 16'h1 << b);
            rd(OFS_CFG2, 16'h1 << b, 16'hffff);
        end
        wr(OFS_CFG2, 16'h001f);
        wr(OFS_PWR, 16'h0001);
        wr(OFS_CFG2, 16'h0000);
        cyc(2);
        #1 cmp({10'h000, cfg}, 16'h0027);
        rd(OFS_CFG2, 16'h0007, 16'hffff);
        wr(OFS_PWR, 16'h0000);
        wr(OFS_CFG2, 16'h0000);
        $display("phy select done");
        // Each level toggles twice so both crossing directions are seen
        foreach (otg_lv[i]) for (int r = 0; r < 2; r++) begin
            wr(OFS_OTG_STAT, 16'h00ff);
            lvl[otg_lv[i]] <= ~lvl[otg_lv[i]];
            slow <= r[0];
            cyc(10);
            rd(OFS_OTG_STAT, 16'h1 << otg_fl[i], 16'h0002 | (16'h1 << otg_fl[i]));
        end
        lvl[8] <= 1'b1;
        cyc(8);
        wr(OFS_OTG_STAT, 16'h0000);
        rd(OFS_OTG_STAT, 16'h0080, 16'h0082);
        wr(OFS_OTG_EN, 16'hffff);
        rd(OFS_OTG_EN, 16'h00fd, 16'hffff);
        wr(OFS_OTG_EN, 16'h0080);
        cyc(2);
        #1 cmp({15'h0000, irq}, 16'h0001);
        wr(OFS_OTG_STAT, 16'h0080);
        cyc(2);
        #1 cmp({15'h0000, irq}, 16'h0000);
        rd(OFS_OTG_STAT, 16'h0000, 16'h0080);
        wr(OFS_OTG_STAT, 16'h0040);
        cyc(MSC + 4);
        rd(OFS_OTG_STAT, 16'h0040, 16'h0040);
        wr(OFS_OTG_STAT, 16'h0020);
        wr(OFS_DEV_STAT, 16'h0001);
        lvl[7] <= 1'b1;
        cyc(MSC + 8);
        rd(OFS_OTG_STAT, 16'h0020, 16'h0020);
        rd(OFS_DEV_STAT, 16'h0001, 16'h0001);
        wr(OFS_DEV_STAT, 16'h0001);
        cyc(KC + 4);
        rd(OFS_DEV_STAT, 16'h0000, 16'h0001);
        lvl[7] <= 1'b0;
        $display("otg flags done");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_DEV_STAT, 16'h00ff);
            evt[i] <= 1'b1;
            cyc(1);
            evt[i] <= 1'b0;
            cyc(8);
            rd(OFS_DEV_STAT, 16'h1 << dev_fl[i], 16'h0040 | (16'h1 << dev_fl[i]));
        end
        evt[1] <= 1'b1;
        cyc(1);
        evt[1] <= 1'b0;
        cyc(8);
        adv_base = adv_cnt;
        wr(OFS_DEV_STAT, 16'h0008);
        wr(OFS_DEV_STAT, 16'h0008);
        cyc(4);
        cmp(16'(adv_cnt - adv_base), 16'h0001);
        wr(OFS_DEV_STAT, 16'h0020);
        lvl[5] <= 1'b1;
        cyc(2);
        lvl[5] <= 1'b0;
        cyc(8);
        rd(OFS_DEV_STAT, 16'h0000, 16'h0020);
        lvl[5] <= 1'b1;
        cyc(KC + 8);
        lvl[5] <= 1'b0;
        rd(OFS_DEV_STAT, 16'h0020, 16'h0020);
        lvl[4] <= 1'b1;
        cyc(IDC + 8);
        rd(OFS_DEV_STAT, 16'h0010, 16'h0010);
        lvl[4] <= 1'b0;
        err <= 8'h01;
        cyc(6);
        rd(OFS_DEV_STAT, 16'h0000, 16'h0002);
        wr(OFS_ERR_EN, 16'h0001);
        wr(OFS_DEV_STAT, 16'h0002);
        cyc(4);
        rd(OFS_DEV_STAT, 16'h0002, 16'h0002);
        wr(OFS_DEV_EN, 16'h0002);
        cyc(2);
        #1 cmp({15'h0000, irq}, 16'h0001);
        err <= 8'h00;
        cyc(6);
        #1 cmp({15'h0000, irq}, 16'h0000);
        $display("device flags done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(OFS_OTG_EN, seed[15:0]);
            rd(OFS_OTG_EN, seed[15:0] & 16'h00fd, 16'hffff);
        end
        cyc(4);
        $display("random enables done");
        report_and_stop();
    end
endmodule : testbench
